// File: logic/adc_ctrl_pkg.sv
/*
 Constants for the converter channel and mode control block: register
 addresses on the special-function-register bus, bit positions, reset
 values, channel codes and conversion length.
 Assumes an 8-bit register bus with 8-bit addresses.
*/
package adc_ctrl_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_MODE_CONTROL = 8'hD8;
   localparam logic [7:0] ADDR_RESULT_LOW   = 8'hD9;
   localparam logic [7:0] ADDR_RESULT_HIGH  = 8'hDA;
   localparam logic [7:0] ADDR_BUSY         = 8'hF5;
   // Control and busy register bit positions
   localparam int BIT_DONE_FLAG  = 7;
   localparam int BIT_CAPTURE    = 6;
   localparam int BIT_CONTINUOUS = 5;
   localparam int BIT_SINGLE     = 4;
   localparam int CHAN_MSB       = 3;
   localparam int CHAN_LSB       = 0;
   localparam int BIT_BUSY       = 7;
   // Result layout
   localparam int RESULT_W       = 12;
   localparam int CHAN_W         = 4;
   // Reset values
   localparam logic [7:0]  MODE_CONTROL_RESET = 8'h00;
   localparam logic [15:0] RESULT_RESET       = 16'h0000;
   localparam logic [7:0]  READ_ZERO          = 8'h00;
   // Channel codes
   localparam logic [3:0] CHAN_LAST_INPUT = 4'h7;
   localparam logic [3:0] CHAN_TEMP       = 4'h8;
   localparam logic [3:0] CHAN_STOP       = 4'hF;
   // Conversion length in core_clk_in cycles
   localparam int         CONV_CLKS_DEFAULT = 17;
   localparam int         CNT_W             = 8;
   localparam logic [7:0] CNT_ZERO          = 8'h00;
   localparam logic [7:0] CNT_ONE           = 8'h01;

   typedef enum logic [0:0] {ST_IDLE, ST_CONVERT} conv_state_type;
endpackage

// File: logic/adc_channel_mode_control.sv
/*
 Channel and mode control register of the successive-approximation
 converter, with its conversion sequencer, result and busy registers.
 Assumes the processor core drives the register bus synchronously to
 core_clk_in, pulses int_vector_in when it vectors to the converter
 interrupt, and that the capture engine supplies the channel identifier
 of the next capture entry on capture_channel_in.
*/
`timescale 1ns/10ps
module adc_channel_mode_control
   import adc_ctrl_pkg::*;
#(
   parameter int CONV_CLKS = CONV_CLKS_DEFAULT
)
(
   input  wire logic                core_clk_in,
   input  wire logic                rstn_in,
   input  wire logic [7:0]          sfr_addr_in,
   input  wire logic                sfr_wr_in,
   input  wire logic                sfr_rd_in,
   input  wire logic [7:0]          sfr_wdata_in,
   input  wire logic                int_vector_in,
   input  wire logic [CHAN_W-1:0]   capture_channel_in,
   input  wire logic [RESULT_W-1:0] sample_in,
   output logic      [7:0]          sfr_rdata_out,
   output logic                     conversion_done_flag_out,
   output logic                     adc_busy_out,
   output logic      [CHAN_W-1:0]   adc_channel_out,
   output logic                     sample_start_out
);

   typedef struct packed {
      conv_state_type    state;
      logic [7:0]        ctrl;
      logic              busy;
      logic [CNT_W-1:0]  cnt;
      logic [CHAN_W-1:0] cur_chan;
      logic [15:0]       result;
      logic [7:0]        rdata;
      logic              start;
   } state_type;

   localparam logic [CNT_W-1:0] CONV_LEN = CNT_W'(CONV_CLKS);

   state_type st;
   state_type next_st;
   logic      wr_ctrl;
   logic      done_now;
   logic      hw_set;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      hit = (addr == target);
   endfunction

   always_comb
   begin
      next_st       = st;
      next_st.start = 1'b0;
      hw_set        = 1'b0;
      wr_ctrl       = sfr_wr_in && hit(sfr_addr_in, ADDR_MODE_CONTROL);
      done_now      = (st.state == ST_CONVERT) && (st.cnt == CNT_ONE);

      if (wr_ctrl)
      begin
         next_st.ctrl = sfr_wdata_in;
         if (st.state == ST_CONVERT)
         begin
            next_st.ctrl[BIT_SINGLE] = st.ctrl[BIT_SINGLE];
         end
      end

      unique case (st.state)
         ST_IDLE:
         begin
            // capture runs from memory channel ids
            if (next_st.ctrl[BIT_CAPTURE])
            begin
               if (capture_channel_in == CHAN_STOP)
               begin
                  hw_set                    = 1'b1;
                  next_st.ctrl[BIT_CAPTURE] = 1'b0;
               end
               else
               begin
                  next_st.cur_chan = capture_channel_in;
                  next_st.state    = ST_CONVERT;
               end
            end
            else if ((next_st.ctrl[BIT_CONTINUOUS] || next_st.ctrl[BIT_SINGLE])
                     && (next_st.ctrl[CHAN_MSB:CHAN_LSB] != CHAN_STOP))
            begin
               next_st.cur_chan = next_st.ctrl[CHAN_MSB:CHAN_LSB];
               next_st.state    = ST_CONVERT;
            end
            if (next_st.state == ST_CONVERT)
            begin
               next_st.cnt   = CONV_LEN;
               next_st.start = 1'b1;
               next_st.busy  = 1'b1;
            end
         end
         ST_CONVERT:
         begin
            next_st.cnt = st.cnt - CNT_ONE;
            if (done_now)
            begin
               // channel code on top of result
               next_st.result = {st.cur_chan, sample_in};
               next_st.busy   = 1'b0;
               next_st.state  = ST_IDLE;
               next_st.ctrl[BIT_SINGLE] = 1'b0;
               if (!st.ctrl[BIT_CAPTURE])
               begin
                  hw_set = 1'b1;
               end
            end
         end
      endcase

      // vectoring clears flag; a set in the same cycle wins
      if (int_vector_in)
      begin
         next_st.ctrl[BIT_DONE_FLAG] = 1'b0;
      end
      if (hw_set)
      begin
         next_st.ctrl[BIT_DONE_FLAG] = 1'b1;
      end

      // Registered read, unmapped addresses read zero
      if (sfr_rd_in)
      begin
         if (hit(sfr_addr_in, ADDR_MODE_CONTROL))
         begin
            next_st.rdata = st.ctrl;
         end
         else if (hit(sfr_addr_in, ADDR_RESULT_LOW))
         begin
            next_st.rdata = st.result[7:0];
         end
         else if (hit(sfr_addr_in, ADDR_RESULT_HIGH))
         begin
            next_st.rdata = st.result[15:8];
         end
         else if (hit(sfr_addr_in, ADDR_BUSY))
         begin
            next_st.rdata           = READ_ZERO;
            next_st.rdata[BIT_BUSY] = st.busy;
         end
         else
         begin
            next_st.rdata = READ_ZERO;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         st.state    <= ST_IDLE;
         st.ctrl     <= MODE_CONTROL_RESET;
         st.busy     <= 1'b0;
         st.cnt      <= CNT_ZERO;
         st.cur_chan <= MODE_CONTROL_RESET[CHAN_MSB:CHAN_LSB];
         st.result   <= RESULT_RESET;
         st.rdata    <= READ_ZERO;
         st.start    <= 1'b0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign sfr_rdata_out            = st.rdata;
   assign conversion_done_flag_out = st.ctrl[BIT_DONE_FLAG];
   assign adc_busy_out             = st.busy;
   assign adc_channel_out          = st.cur_chan;
   assign sample_start_out         = st.start;

   // Checks
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);

   // Cycles spent busy since the start strobe
   logic [CNT_W-1:0] busy_len;
   always_ff @(posedge core_clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         busy_len <= CNT_ZERO;
      end
      else
      begin
         busy_len <= st.busy ? busy_len + CNT_ONE : CNT_ZERO;
      end
   end

   property p_flag_on_done;
      done_now && !st.ctrl[BIT_CAPTURE] |=> conversion_done_flag_out;
   endproperty
   a_flag_on_done: assert property (p_flag_on_done) else $error("done flag not set after conversion");

   property p_flag_on_block;
      st.state == ST_IDLE && st.ctrl[BIT_CAPTURE] && !wr_ctrl && capture_channel_in == CHAN_STOP
      |=> conversion_done_flag_out && !st.ctrl[BIT_CAPTURE];
   endproperty
   a_flag_on_block: assert property (p_flag_on_block) else $error("capture block end missed");

   property p_vector_clear;
      int_vector_in && !hw_set && !wr_ctrl |=> !conversion_done_flag_out;
   endproperty
   a_vector_clear: assert property (p_vector_clear) else $error("flag not cleared on vector");

   property p_capture_start;
      st.state == ST_IDLE && st.ctrl[BIT_CAPTURE] && !wr_ctrl && capture_channel_in != CHAN_STOP
      |=> sample_start_out && adc_busy_out && adc_channel_out == $past(capture_channel_in);
   endproperty
   a_capture_start: assert property (p_capture_start) else $error("capture conversion not started");

   property p_continuous;
      done_now && st.ctrl[BIT_CONTINUOUS] && !st.ctrl[BIT_CAPTURE] && !wr_ctrl
      ##1 (!wr_ctrl && st.ctrl[CHAN_MSB:CHAN_LSB] != CHAN_STOP) |=> adc_busy_out;
   endproperty
   a_continuous: assert property (p_continuous) else $error("continuous mode did not restart");

   property p_single_len;
      // Counter lags busy by one edge, so it shows one less on the last cycle
      done_now |-> busy_len == CONV_LEN - CNT_ONE ##1 !st.ctrl[BIT_SINGLE] && !adc_busy_out;
   endproperty
   a_single_len: assert property (p_single_len) else $error("conversion length or single clear wrong");

   property p_reg_channel;
      st.state == ST_IDLE && wr_ctrl && !sfr_wdata_in[BIT_CAPTURE] && sfr_wdata_in[BIT_SINGLE]
      && sfr_wdata_in[CHAN_MSB:CHAN_LSB] != CHAN_STOP
      |=> sample_start_out && adc_channel_out == $past(sfr_wdata_in[CHAN_MSB:CHAN_LSB]);
   endproperty
   a_reg_channel: assert property (p_reg_channel) else $error("wrong register channel converted");

   property p_reset_value;
      $past(!rstn_in) |-> st.ctrl == MODE_CONTROL_RESET && !adc_busy_out;
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("control register not zero after reset");

   property p_result;
      done_now |=> st.result == {$past(st.cur_chan), $past(sample_in)};
   endproperty
   a_result: assert property (p_result) else $error("result or channel tag wrong");

   property p_busy_read;
      sfr_rd_in && hit(sfr_addr_in, ADDR_BUSY) |=> sfr_rdata_out[BIT_BUSY] == $past(st.busy);
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("busy read mismatch");

   property p_ignore_single;
      st.state == ST_CONVERT && !done_now && wr_ctrl
      |=> st.ctrl[BIT_SINGLE] == $past(st.ctrl[BIT_SINGLE]) && $stable(adc_channel_out);
   endproperty
   a_ignore_single: assert property (p_ignore_single) else $error("single request accepted while busy");

   c_single_done: cover property (done_now && st.ctrl[BIT_SINGLE]);
   c_block_done:  cover property (st.state == ST_IDLE && st.ctrl[BIT_CAPTURE] && capture_channel_in == CHAN_STOP);
   c_restart:     cover property (done_now && st.ctrl[BIT_CONTINUOUS] ##2 adc_busy_out);
endmodule

// File: tb/adc_channel_mode_control_test.sv
/*
 Self-checking bench for the converter channel and mode control block.
 Assumes the package and design under logic/, with CONV_CLKS cut to 3.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module adc_channel_mode_control_test
   import adc_ctrl_pkg::*;
;
   localparam int CONV = 3;
   logic        core_clk_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic [7:0]  sfr_addr_in = 8'h00;
   logic        sfr_wr_in = 1'b0;
   logic        sfr_rd_in = 1'b0;
   logic [7:0]  sfr_wdata_in = 8'h00;
   logic        int_vector_in = 1'b0;
   logic [3:0]  capture_channel_in = 4'h0;
   logic [11:0] sample_in = 12'hABC;
   logic [7:0]  sfr_rdata_out;
   logic        conversion_done_flag_out;
   logic        adc_busy_out;
   logic [3:0]  adc_channel_out;
   logic        sample_start_out;
   int          err_total = 0;
   int          cmp_count = 0;

   adc_channel_mode_control #(.CONV_CLKS(CONV)) dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
      .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
      .int_vector_in(int_vector_in), .capture_channel_in(capture_channel_in), .sample_in(sample_in),
      .sfr_rdata_out(sfr_rdata_out), .conversion_done_flag_out(conversion_done_flag_out),
      .adc_busy_out(adc_busy_out), .adc_channel_out(adc_channel_out), .sample_start_out(sample_start_out));

   always #12.5 core_clk_in = ~core_clk_in;

   task wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      sfr_addr_in <= a;
      sfr_wdata_in <= d;
      sfr_wr_in <= 1'b1;
      @(posedge core_clk_in);
      sfr_wr_in <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk_in);
      sfr_addr_in <= a;
      sfr_rd_in <= 1'b1;
      @(posedge core_clk_in);
      sfr_rd_in <= 1'b0;
      #1 `CHK(sfr_rdata_out, e)
   endtask

   // Bounded wait; returns one step after the edge that shows the level
   task wait_busy(input logic lvl, output int n);
      // Step off the edge so a level launched there is settled
      #1;
      n = 0;
      while (adc_busy_out !== lvl && n < 60)
      begin
         @(posedge core_clk_in);
         #1 n++;
      end
      if (n >= 60)
      begin
         err_total++;
         wrap_up();
      end
   endtask

   task pulse_int();
      @(posedge core_clk_in);
      int_vector_in <= 1'b1;
      @(posedge core_clk_in);
      int_vector_in <= 1'b0;
      #1 `CHK(conversion_done_flag_out, 1'b0)
   endtask

   task t_reset();
      `CHK({conversion_done_flag_out, adc_busy_out, sample_start_out}, 3'h0)
      rd(ADDR_MODE_CONTROL, 8'h00);
      rd(ADDR_BUSY, 8'h00);
      rd(8'h55, 8'h00);
   endtask

   task t_single();
      int n;
      wr(ADDR_MODE_CONTROL, 8'h13);
      #1 `CHK({adc_busy_out, sample_start_out, adc_channel_out}, 6'h33)
      wait_busy(1'b0, n);
      `CHK(n, CONV)
      `CHK(conversion_done_flag_out, 1'b1)
      rd(ADDR_MODE_CONTROL, 8'h83);
      rd(ADDR_RESULT_HIGH, 8'h3A);
      rd(ADDR_RESULT_LOW, 8'hBC);
   endtask

   // Second request lands mid-conversion; only one conversion may run
   task t_ignore();
      int n;
      wr(ADDR_MODE_CONTROL, 8'h12);
      wr(ADDR_MODE_CONTROL, 8'h15);
      wait_busy(1'b0, n);
      `CHK(adc_channel_out, 4'h2)
      repeat (3) @(posedge core_clk_in);
      #1 `CHK(adc_busy_out, 1'b0)
      rd(ADDR_MODE_CONTROL, 8'h85);
   endtask

   task t_cont();
      int n;
      wr(ADDR_MODE_CONTROL, 8'h26);
      wait_busy(1'b0, n);
      @(posedge core_clk_in);
      #1 `CHK({adc_busy_out, adc_channel_out}, 5'h16)
      wr(ADDR_MODE_CONTROL, 8'h00);
      wait_busy(1'b0, n);
      repeat (3) @(posedge core_clk_in);
      #1 `CHK(adc_busy_out, 1'b0)
   endtask

   // Channel field holds 1, memory entry says 5
   task t_capture();
      int n;
      @(posedge core_clk_in);
      capture_channel_in <= 4'h5;
      wr(ADDR_MODE_CONTROL, 8'h41);
      wait_busy(1'b1, n);
      `CHK(adc_channel_out, 4'h5)
      @(posedge core_clk_in);
      capture_channel_in <= CHAN_STOP;
      wait_busy(1'b0, n);
      `CHK(conversion_done_flag_out, 1'b0)
      repeat (3) @(posedge core_clk_in);
      #1 `CHK({conversion_done_flag_out, adc_busy_out}, 2'h2)
      rd(ADDR_MODE_CONTROL, 8'h81);
      wr(ADDR_MODE_CONTROL, 8'h1F);
      repeat (3) @(posedge core_clk_in);
      #1 `CHK(adc_busy_out, 1'b0)
   endtask

   initial
   begin
      repeat (12) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      t_reset();
      t_single();
      pulse_int();
      t_ignore();
      pulse_int();
      t_cont();
      pulse_int();
      t_capture();
      wrap_up();
   end
endmodule
